// File: hdl/debug_uart_defines.svh
`ifndef DEBUG_UART_DEFINES_SVH
`define DEBUG_UART_DEFINES_SVH

// register byte addresses
`define ADDR_CTRL 32'hfffff200
`define ADDR_MODE 32'hfffff204
`define ADDR_IRQ_ENABLE_SET 32'hfffff208
`define ADDR_IRQ_ENABLE_CLEAR 32'h0ffff20c
`define ADDR_IRQ_MASK_VIEW 32'hfffff210
`define ADDR_LINE_STATUS 32'hfffff214
`define ADDR_RX_HOLDING 32'hfffff218
`define ADDR_TX_HOLDING 32'h0ffff21c
`define ADDR_BAUD_DIVISOR 32'h0ffff220

// status, enable and mask bit positions
`define BIT_RX_CHAR_AVAIL 0
`define BIT_TX_HOLD_FREE 1
`define BIT_OVERRUN 5
`define BIT_FRAME_ERR 6
`define BIT_PARITY_ERR 7
`define BIT_TX_ALL_EMPTY 9
`define BIT_DBG_WRITE 30
`define BIT_DBG_READ 31
`define IRQ_SRC_BITS 32'hc00002e3

// control strobes
`define BIT_RX_RESET 2
`define BIT_TX_RESET 3
`define BIT_RX_ENABLE 4
`define BIT_RX_DISABLE 5
`define BIT_TX_ENABLE 6
`define BIT_TX_DISABLE 7
`define BIT_STATUS_CLEAR 8

// parity field of the mode register
`define PARITY_LSB 9
`define PARITY_MSB 11

// reset values
`define RESET_MASK 32'h00000000
`define RESET_DIVISOR 16'h0000
`define RESET_PARITY 3'h0
`define RESET_SYNC 3'h1

// sixteen ticks per bit, sampled at the middle
`define OS_LAST 4'hf
`define OS_HALF 4'h7
`define BIT_LAST 3'h7

`endif

// File: hdl/debug_uart_pkg.sv
`default_nettype none
package debug_uart_pkg;

    typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_par, rx_stop} rx_state_t;
    typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_par, tx_stop} tx_state_t;

    typedef struct packed {
        logic frame_err;
        logic par_err;
        logic [7:0] data;
    } rx_char_t;

    // mode 1xx means no parity bit; caller checks mode[2]
    function automatic logic parity_of(input logic [2:0] mode, input logic [7:0] d);
        case (mode[1:0])
            2'h0: parity_of = ^d;
            2'h1: parity_of = ~^d;
            2'h2: parity_of = 1'b0;
            default: parity_of = 1'b1;
        endcase
    endfunction

endpackage

`default_nettype wire

// File: hdl/baud_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "debug_uart_defines.svh"

module baud_tick_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] divisor,
    output logic tick
);
    logic [15:0] cnt;

    // divisor 0 stops the ticks, 1 ticks every clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (divisor == 16'h0000) begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt >= divisor - 16'h0001) begin
            cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// File: hdl/char_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// File: hdl/debug_uart_status_irq_regs.sv
// Function
// - enable-set write ones enable irq sources
// - enable-clear write ones disable irq sources
// - mask view reads currently enabled sources
// - char available set on received character
// - char available cleared by read, disabled
// - hold free unless char waits, tx off
// - overrun sticky until status clear
// - framing error sticky until status clear
// - parity error sticky until status clear
// - all empty only when buffer, shifter idle
// - bits 30, 31 mirror debug channel
// - rx holding returns last character
// - tx holding queues next character
// - divisor zero off, else clock/(16*div)
// - status clear resets three error flags
// - all empty rises after final stop
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "debug_uart_defines.svh"

module debug_uart_status_irq_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic dbg_chan_read_pending,
    input wire logic dbg_chan_write_pending,
    output logic irq
);
    localparam logic [2:0] SYNC_INIT = `RESET_SYNC;

    logic acc;
    logic wr_fire;
    logic rd_fire;
    logic [31:0] irq_mask;
    logic [15:0] baud_div_value;
    logic [2:0] parity_mode;
    logic rx_en;
    logic tx_en;
    logic ctrl_wr;
    logic rx_rst;
    logic tx_rst;
    logic status_clear_cmd;
    logic os_tick;
    logic [2:0] sync_in;
    logic [2:0] sync_s1;
    logic [2:0] sync_s2;
    logic [2:0] sync_s3;
    logic [2:0] sync_val;
    logic rx_line;
    debug_uart_pkg::rx_state_t rx_state;
    logic [3:0] rx_os;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift;
    logic rx_par_bit;
    logic rx_done;
    debug_uart_pkg::rx_char_t rx_evt;
    logic rx_avail_raw;
    logic [7:0] rx_char_value;
    logic overrun_flag;
    logic frame_err_flag;
    logic parity_err_flag;
    debug_uart_pkg::tx_state_t tx_state;
    logic [3:0] tx_os;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic tx_par;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [31:0] status_vec;
    logic [31:0] rd_val;
    logic rd_hit;

    // apb: one wait state, answer on the second access cycle
    assign acc = psel & penable;
    assign wr_fire = acc & pready & pwrite;
    assign rd_fire = acc & pready & ~pwrite;
    assign ctrl_wr = wr_fire && (paddr == `ADDR_CTRL);
    assign rx_rst = ctrl_wr & pwdata[`BIT_RX_RESET];
    assign tx_rst = ctrl_wr & pwdata[`BIT_TX_RESET];
    assign status_clear_cmd = ctrl_wr & pwdata[`BIT_STATUS_CLEAR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc & ~pready;
            if (acc && !pready) begin
                prdata <= pwrite ? 32'h00000000 : rd_val;
                pslverr <= ~rd_hit;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `RESET_MASK;
        end else if (wr_fire && paddr == `ADDR_IRQ_ENABLE_SET) begin
            irq_mask <= irq_mask | (pwdata & `IRQ_SRC_BITS);
        end else if (wr_fire && paddr == `ADDR_IRQ_ENABLE_CLEAR) begin
            irq_mask <= irq_mask & ~(pwdata & `IRQ_SRC_BITS);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_div_value <= `RESET_DIVISOR;
            parity_mode <= `RESET_PARITY;
        end else if (wr_fire && paddr == `ADDR_BAUD_DIVISOR) begin
            baud_div_value <= pwdata[15:0];
        end else if (wr_fire && paddr == `ADDR_MODE) begin
            parity_mode <= pwdata[`PARITY_MSB:`PARITY_LSB];
        end
    end

    // reset or disable beats enable in the same write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_en <= 1'b0;
            tx_en <= 1'b0;
        end else if (ctrl_wr) begin
            if (pwdata[`BIT_RX_RESET] || pwdata[`BIT_RX_DISABLE]) begin
                rx_en <= 1'b0;
            end else if (pwdata[`BIT_RX_ENABLE]) begin
                rx_en <= 1'b1;
            end
            if (pwdata[`BIT_TX_RESET] || pwdata[`BIT_TX_DISABLE]) begin
                tx_en <= 1'b0;
            end else if (pwdata[`BIT_TX_ENABLE]) begin
                tx_en <= 1'b1;
            end
        end
    end

    baud_tick_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divisor(baud_div_value),
        .tick(os_tick)
    );

    // pin inputs: three stages, a change counts once stages two and three agree
    assign sync_in = {dbg_chan_read_pending, dbg_chan_write_pending, rxd};
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_s1[i] <= SYNC_INIT[i];
                sync_s2[i] <= SYNC_INIT[i];
                sync_s3[i] <= SYNC_INIT[i];
                sync_val[i] <= SYNC_INIT[i];
            end else begin
                sync_s1[i] <= sync_in[i];
                sync_s2[i] <= sync_s1[i];
                sync_s3[i] <= sync_s2[i];
                if (sync_s2[i] == sync_s3[i]) begin
                    sync_val[i] <= sync_s3[i];
                end
            end
        end
    end
    assign rx_line = sync_val[0];

    // receiver: a start bit is rechecked at mid-bit to reject glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= debug_uart_pkg::rx_idle;
            rx_os <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= 8'h00;
            rx_par_bit <= 1'b0;
            rx_done <= 1'b0;
            rx_evt <= '0;
        end else begin
            rx_done <= 1'b0;
            if (rx_rst || !rx_en) begin
                rx_state <= debug_uart_pkg::rx_idle;
            end else if (os_tick) begin
                rx_os <= rx_os + 4'h1;
                case (rx_state)
                    debug_uart_pkg::rx_idle: begin
                        rx_os <= 4'h0;
                        if (!rx_line) begin
                            rx_state <= debug_uart_pkg::rx_start;
                        end
                    end
                    debug_uart_pkg::rx_start: begin
                        if (rx_os == `OS_HALF) begin
                            rx_os <= 4'h0;
                            rx_idx <= 3'h0;
                            rx_state <= rx_line ? debug_uart_pkg::rx_idle
                                                : debug_uart_pkg::rx_data;
                        end
                    end
                    debug_uart_pkg::rx_data: begin
                        if (rx_os == `OS_LAST) begin
                            rx_shift <= {rx_line, rx_shift[7:1]};
                            rx_idx <= rx_idx + 3'h1;
                            if (rx_idx == `BIT_LAST) begin
                                rx_state <= parity_mode[2] ? debug_uart_pkg::rx_stop
                                                           : debug_uart_pkg::rx_par;
                            end
                        end
                    end
                    debug_uart_pkg::rx_par: begin
                        if (rx_os == `OS_LAST) begin
                            rx_par_bit <= rx_line;
                            rx_state <= debug_uart_pkg::rx_stop;
                        end
                    end
                    default: begin
                        if (rx_os == `OS_LAST) begin
                            rx_done <= 1'b1;
                            rx_evt.data <= rx_shift;
                            rx_evt.frame_err <= ~rx_line;
                            rx_evt.par_err <= ~parity_mode[2] &
                                (rx_par_bit != debug_uart_pkg::parity_of(parity_mode, rx_shift));
                            rx_state <= debug_uart_pkg::rx_idle;
                        end
                    end
                endcase
            end
        end
    end

    // new character wins over a read or reset in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_avail_raw <= 1'b0;
            rx_char_value <= 8'h00;
        end else if (rx_done) begin
            rx_avail_raw <= 1'b1;
            rx_char_value <= rx_evt.data;
        end else if (rx_rst || (rd_fire && paddr == `ADDR_RX_HOLDING)) begin
            rx_avail_raw <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_flag <= 1'b0;
            frame_err_flag <= 1'b0;
            parity_err_flag <= 1'b0;
        end else begin
            if (rx_done && rx_avail_raw) begin
                overrun_flag <= 1'b1;
            end else if (status_clear_cmd) begin
                overrun_flag <= 1'b0;
            end
            if (rx_done && rx_evt.frame_err) begin
                frame_err_flag <= 1'b1;
            end else if (status_clear_cmd) begin
                frame_err_flag <= 1'b0;
            end
            if (rx_done && rx_evt.par_err) begin
                parity_err_flag <= 1'b1;
            end else if (status_clear_cmd) begin
                parity_err_flag <= 1'b0;
            end
        end
    end

    // a write while disabled or with both entries taken is dropped
    assign fifo_in_valid = wr_fire && (paddr == `ADDR_TX_HOLDING) && tx_en;
    assign fifo_out_ready = (tx_state == debug_uart_pkg::tx_idle) && tx_en && !tx_rst;

    char_fifo #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // transmitter; reset aborts the frame and returns the line to idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= debug_uart_pkg::tx_idle;
            tx_os <= 4'h0;
            tx_idx <= 3'h0;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            txd <= 1'b1;
        end else if (tx_rst) begin
            tx_state <= debug_uart_pkg::tx_idle;
            txd <= 1'b1;
        end else if (tx_state == debug_uart_pkg::tx_idle) begin
            if (fifo_out_valid && fifo_out_ready) begin
                tx_shift <= fifo_out_data;
                tx_par <= debug_uart_pkg::parity_of(parity_mode, fifo_out_data);
                tx_os <= 4'h0;
                txd <= 1'b0;
                tx_state <= debug_uart_pkg::tx_start;
            end
        end else if (os_tick) begin
            tx_os <= tx_os + 4'h1;
            if (tx_os == `OS_LAST) begin
                case (tx_state)
                    debug_uart_pkg::tx_start: begin
                        tx_idx <= 3'h0;
                        txd <= tx_shift[0];
                        tx_state <= debug_uart_pkg::tx_data;
                    end
                    debug_uart_pkg::tx_data: begin
                        tx_idx <= tx_idx + 3'h1;
                        if (tx_idx != `BIT_LAST) begin
                            txd <= tx_shift[tx_idx + 3'h1];
                        end else if (parity_mode[2]) begin
                            txd <= 1'b1;
                            tx_state <= debug_uart_pkg::tx_stop;
                        end else begin
                            txd <= tx_par;
                            tx_state <= debug_uart_pkg::tx_par;
                        end
                    end
                    debug_uart_pkg::tx_par: begin
                        txd <= 1'b1;
                        tx_state <= debug_uart_pkg::tx_stop;
                    end
                    default: begin
                        tx_state <= debug_uart_pkg::tx_idle;
                    end
                endcase
            end
        end
    end

    always_comb begin
        status_vec = 32'h00000000;
        status_vec[`BIT_RX_CHAR_AVAIL] = rx_avail_raw & rx_en;
        status_vec[`BIT_TX_HOLD_FREE] = tx_en & ~fifo_out_valid;
        status_vec[`BIT_OVERRUN] = overrun_flag;
        status_vec[`BIT_FRAME_ERR] = frame_err_flag;
        status_vec[`BIT_PARITY_ERR] = parity_err_flag;
        status_vec[`BIT_TX_ALL_EMPTY] = tx_en & ~fifo_out_valid &
            (tx_state == debug_uart_pkg::tx_idle);
        status_vec[`BIT_DBG_WRITE] = sync_val[1];
        status_vec[`BIT_DBG_READ] = sync_val[2];
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        if (paddr == `ADDR_IRQ_MASK_VIEW) begin
            rd_val = irq_mask;
        end else if (paddr == `ADDR_LINE_STATUS) begin
            rd_val = status_vec;
        end else if (paddr == `ADDR_RX_HOLDING) begin
            rd_val = {24'h000000, rx_char_value};
        end else if (paddr == `ADDR_BAUD_DIVISOR) begin
            rd_val = {16'h0000, baud_div_value};
        end else if (paddr == `ADDR_MODE) begin
            rd_val = {20'h00000, parity_mode, 9'h000};
        end else if (paddr != `ADDR_CTRL && paddr != `ADDR_IRQ_ENABLE_SET &&
                     paddr != `ADDR_IRQ_ENABLE_CLEAR && paddr != `ADDR_TX_HOLDING) begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_vec & irq_mask);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence stop_bit_done;
        tx_state == debug_uart_pkg::tx_stop && !tx_rst && os_tick && tx_os == `OS_LAST;
    endsequence
    sequence mask_read_setup;
        acc && !pready && !pwrite && paddr == `ADDR_IRQ_MASK_VIEW;
    endsequence

    chk_set_enables: assert property (
        wr_fire && paddr == `ADDR_IRQ_ENABLE_SET |=>
            ((irq_mask & $past(pwdata) & `IRQ_SRC_BITS) == ($past(pwdata) & `IRQ_SRC_BITS)))
        else $error("enable-set write did not enable sources");
    chk_clear_disables: assert property (
        wr_fire && paddr == `ADDR_IRQ_ENABLE_CLEAR |=> ((irq_mask & $past(pwdata)) == 32'h0))
        else $error("enable-clear write did not disable sources");
    chk_mask_readback: assert property (
        mask_read_setup |=> pready && prdata == $past(irq_mask))
        else $error("mask view read returned wrong value");
    chk_rx_avail_set: assert property (
        rx_done |=> rx_avail_raw && rx_char_value == $past(rx_evt.data))
        else $error("received character not made available");
    chk_rx_read_clears: assert property (
        rd_fire && paddr == `ADDR_RX_HOLDING && !rx_done |=> !status_vec[`BIT_RX_CHAR_AVAIL])
        else $error("char available still set after read");
    chk_overrun_set: assert property (
        rx_done && rx_avail_raw |=> overrun_flag)
        else $error("overrun not recorded");
    chk_errors_sticky: assert property (
        frame_err_flag && !status_clear_cmd |=> frame_err_flag [*2] or status_clear_cmd)
        else $error("framing error flag dropped without clear");
    chk_status_clear: assert property (
        status_clear_cmd && !rx_done |=> !overrun_flag && !frame_err_flag && !parity_err_flag)
        else $error("status clear left an error flag set");
    chk_empty_after_stop: assert property (
        stop_bit_done ##1 (tx_en && !fifo_out_valid) |-> status_vec[`BIT_TX_ALL_EMPTY])
        else $error("all-empty not raised after stop bit");
    chk_irq_follows: assert property (
        ##1 irq == $past(|(status_vec & irq_mask)))
        else $error("irq does not follow enabled flags");
endmodule

`default_nettype wire

// File: tb/term_model.sv
`timescale 1ns/10ps
`default_nettype none

module term_model #(
    parameter int BIT = 16
) (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got[$];
    int par_bad = 0;

    initial rxd = 1'b1;

    // even parity frame; bp and bs corrupt parity and stop on purpose
    task automatic send(input logic [7:0] d, input logic bp, input logic bs);
        logic [10:0] f;
        f = {~bs, ^d ^ bp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (BIT - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge pclk);
    endtask

    // mid-bit sampling, as a real terminal would
    initial begin
        logic [9:0] s;
        forever begin
            @(negedge txd);
            repeat (BIT / 2) @(posedge pclk);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT) @(posedge pclk);
                s[i] = txd;
            end
            if (s[8] !== ^s[7:0] || s[9] !== 1'b1) par_bad++;
            got.push_back(s[7:0]);
        end
    end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "debug_uart_defines.svh"

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, e;
    logic dbg_chan_read_pending, dbg_chan_write_pending;
    logic [31:0] paddr, pwdata, prdata, r;
    int error_cnt = 0;
    int checked = 0;

    debug_uart_status_irq_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .dbg_chan_read_pending,
        .dbg_chan_write_pending, .irq);
    term_model term (.pclk, .txd, .rxd);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task finish_test;
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic x);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are taken at the completing rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        x = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            finish_test();
        end
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask

    // polls status; a character at divisor 1 takes under 200 clocks
    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, `ADDR_LINE_STATUS, 32'h0, r, e);
            n++;
        end while (r[b] !== v && n < 400);
        chk(32'(r[b]), 32'(v));
        if (r[b] !== v)
            finish_test();
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        dbg_chan_read_pending = 1'b0;
        dbg_chan_write_pending = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_IRQ_MASK_VIEW, 32'hffffffff, 32'h0);
        rd(`ADDR_LINE_STATUS, 32'h000002e3, 32'h0);
        apb(1'b0, 32'hfffff224, 32'h0, r, e);
        chk(32'(e), 32'h1);
        wr(`ADDR_IRQ_ENABLE_SET, `IRQ_SRC_BITS);
        rd(`ADDR_IRQ_MASK_VIEW, 32'hffffffff, 32'hc00002e3);
        wr(`ADDR_IRQ_ENABLE_CLEAR, 32'hc00002c3);
        wr(`ADDR_IRQ_ENABLE_SET, 32'h0);
        rd(`ADDR_IRQ_MASK_VIEW, 32'hffffffff, 32'h20);
        wr(`ADDR_BAUD_DIVISOR, 32'h1);
        rd(`ADDR_BAUD_DIVISOR, 32'h0000ffff, 32'h1);
        wr(`ADDR_CTRL, 32'h50);
        rd(`ADDR_LINE_STATUS, 32'h202, 32'h202);
        dbg_chan_read_pending <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(`ADDR_LINE_STATUS, 32'hc0000000, 32'h80000000);
        dbg_chan_read_pending <= 1'b0;
        dbg_chan_write_pending <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(`ADDR_LINE_STATUS, 32'hc0000000, 32'h40000000);
        term.send(8'ha5, 1'b0, 1'b0);
        wait_bit(0, 1'b1);
        rd(`ADDR_RX_HOLDING, 32'hff, 32'ha5);
        rd(`ADDR_LINE_STATUS, 32'h1, 32'h0);
        chk(32'(irq), 32'h0);
        term.send(8'h11, 1'b0, 1'b0);
        term.send(8'h22, 1'b0, 1'b0);
        rd(`ADDR_LINE_STATUS, 32'h21, 32'h21);
        rd(`ADDR_RX_HOLDING, 32'hff, 32'h22);
        chk(32'(irq), 32'h1);
        term.send(8'h33, 1'b1, 1'b0);
        term.send(8'h44, 1'b0, 1'b1);
        rd(`ADDR_LINE_STATUS, 32'he0, 32'he0);
        wr(`ADDR_CTRL, 32'h100);
        rd(`ADDR_LINE_STATUS, 32'he0, 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        wr(`ADDR_TX_HOLDING, 32'h3c);
        wr(`ADDR_TX_HOLDING, 32'hc3);
        rd(`ADDR_LINE_STATUS, 32'h202, 32'h0);
        wait_bit(9, 1'b1);
        chk(32'(term.got.size()), 32'h2);
        chk({24'h0, term.got[0]}, 32'h3c);
        chk({24'h0, term.got[1]}, 32'hc3);
        chk(32'(term.par_bad), 32'h0);
        // divisor zero stops the ticks: a new character stays stuck in its start bit
        wr(`ADDR_BAUD_DIVISOR, 32'h0);
        wr(`ADDR_TX_HOLDING, 32'h55);
        repeat (40) @(posedge pclk);
        rd(`ADDR_LINE_STATUS, 32'h200, 32'h0);
        chk(32'(txd), 32'h0);
        chk(32'(term.got.size()), 32'h2);
        finish_test();
    end
endmodule

`default_nettype wire
